// ===== cfx_core.sv
// cfx_core.sv: fetch-execute core with one prefetch stage and split memory buses
// Operation
// - Program fetch and data access run on separate buses; only table reads borrow the program bus.
// - The next instruction word is fetched while the current one executes.
// - Thirty-two 8-bit registers, each readable and writable in one cycle.
// - An ALU instruction reads two registers, computes and writes back in one cycle.
// - Register pairs 26/27, 28/29 and 30/31 form 16-bit data pointers.
// - The pointer in registers 30/31 also addresses program memory for table reads.
// - Instructions are one or two 16-bit words long.
// - Status flags follow every arithmetic result.
`default_nettype none
`include "cfx_defs.svh"
module cfx_core
  import cfx_pkg::*;
#(
  parameter int PC_W = `CFX_PC_W
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  output logic [PC_W-1:0] imem_addr_o,
  input wire logic [`CFX_IW-1:0] imem_rdata_i,
  output logic [`CFX_AW-1:0] dmem_addr_o,
  output logic [`CFX_DW-1:0] dmem_wdata_o,
  output logic dmem_we_o,
  output logic dmem_re_o,
  input wire logic [`CFX_DW-1:0] dmem_rdata_i,
  output logic [`CFX_DW-1:0] status_o
);
  cfx_state_t state_reg, state_next;
  logic [PC_W-1:0] pc_reg, pc_next, ret_reg, ret_next;
  logic vld_reg, vld_next;
  logic [`CFX_AW-1:0] daddr_reg, daddr_next;
  logic [`CFX_DW-1:0] dwd_reg, dwd_next;
  logic dwe_reg, dwe_next, dre_reg, dre_next;
  logic [`CFX_DW-1:0] sreg_reg, sreg_next;
  logic [`CFX_RA_W-1:0] dst_reg, dst_next;

  logic rf_we;
  logic [`CFX_RA_W-1:0] rf_wa;
  logic [`CFX_DW-1:0] rf_wd, rd_a, rd_b;
  logic [`CFX_AW-1:0] ptr_x, ptr_y, ptr_z, sel_ptr;
  logic [`CFX_IW-1:0] ir;
  cfx_op_t op;
  logic exec;
  logic [`CFX_RA_W-1:0] fld_rd, fld_rs;
  logic [PC_W-1:0] rel_tgt, z_word;
  logic [`CFX_DW:0] sum;
  logic [`CFX_DW-1:0] alu_res, alu_flags;

  function automatic logic [`CFX_AW-1:0] ptr_of(input logic [1:0] s,
      input logic [`CFX_AW-1:0] x, input logic [`CFX_AW-1:0] y,
      input logic [`CFX_AW-1:0] z);
    case (s)
      2'h0: return x;
      2'h1: return y;
      default: return z;
    endcase
  endfunction

  // prefetched word sits on the program bus; no instruction register needed
  assign ir = imem_rdata_i;
  assign op = cfx_op_t'(ir[`CFX_OP_HI:`CFX_OP_LO]);
  assign exec = (state_reg == S_RUN) && vld_reg;
  assign fld_rd = ir[`CFX_RD_HI:`CFX_RD_LO];
  assign fld_rs = ir[`CFX_RS_HI:`CFX_RS_LO];
  assign sel_ptr = ptr_of(ir[`CFX_PS_HI:`CFX_PS_LO], ptr_x, ptr_y, ptr_z);
  // pc already points one past the executing word, so offsets are from there
  assign rel_tgt = pc_reg + PC_W'($signed(ir[`CFX_K12_HI:0]));
  assign z_word = PC_W'(ptr_z[`CFX_AW-1:1]);

  cfx_regfile #(
    .NREG(`CFX_NREG)
  ) u_regfile (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .we_i(rf_we),
    .waddr_i(rf_wa),
    .wdata_i(rf_wd),
    .raddr_a_i(fld_rd),
    .raddr_b_i(fld_rs),
    .rdata_a_o(rd_a),
    .rdata_b_o(rd_b),
    .ptr_x_o(ptr_x),
    .ptr_y_o(ptr_y),
    .ptr_z_o(ptr_z)
  );

  always_comb begin
    sum = '0;
    alu_flags = sreg_reg;
    case (op)
      OP_ADD: sum = {1'b0, rd_a} + {1'b0, rd_b};
      OP_SUB: sum = {1'b0, rd_a} - {1'b0, rd_b};
      OP_AND: sum = {1'b0, rd_a & rd_b};
      OP_OR: sum = {1'b0, rd_a | rd_b};
      default: sum = '0;
    endcase
    alu_res = sum[`CFX_DW-1:0];
    alu_flags[`CFX_FLAG_Z] = (alu_res == '0);
    alu_flags[`CFX_FLAG_N] = alu_res[7];
    if (op == OP_ADD) begin
      alu_flags[`CFX_FLAG_C] = sum[8];
      alu_flags[`CFX_FLAG_V] = (rd_a[7] & rd_b[7] & ~alu_res[7])
          | (~rd_a[7] & ~rd_b[7] & alu_res[7]);
      alu_flags[`CFX_FLAG_H] = (rd_a[3] & rd_b[3]) | (rd_b[3] & ~alu_res[3])
          | (~alu_res[3] & rd_a[3]);
    end else if (op == OP_SUB) begin
      alu_flags[`CFX_FLAG_C] = sum[8];
      alu_flags[`CFX_FLAG_V] = (rd_a[7] & ~rd_b[7] & ~alu_res[7])
          | (~rd_a[7] & rd_b[7] & alu_res[7]);
      alu_flags[`CFX_FLAG_H] = (~rd_a[3] & rd_b[3]) | (rd_b[3] & alu_res[3])
          | (alu_res[3] & ~rd_a[3]);
    end else begin
      // logic ops clear overflow and leave carry and half carry alone
      alu_flags[`CFX_FLAG_V] = 1'b0;
    end
    alu_flags[`CFX_FLAG_S] = alu_flags[`CFX_FLAG_N] ^ alu_flags[`CFX_FLAG_V];
  end

  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg + 1'b1;
    vld_next = 1'b1;
    ret_next = ret_reg;
    daddr_next = daddr_reg;
    dwd_next = dwd_reg;
    dwe_next = 1'b0;
    dre_next = 1'b0;
    sreg_next = sreg_reg;
    dst_next = dst_reg;
    rf_we = 1'b0;
    rf_wa = fld_rd;
    rf_wd = alu_res;
    case (state_reg)
      S_RUN: begin
        if (vld_reg) begin
          case (op)
            OP_ADD, OP_SUB, OP_AND, OP_OR: begin
              rf_we = 1'b1;
              sreg_next = alu_flags;
            end
            OP_MOV: begin
              rf_we = 1'b1;
              rf_wd = rd_b;
            end
            OP_LDI: begin
              rf_we = 1'b1;
              rf_wd = {1'b0, ir[`CFX_K7_HI:0]};
            end
            OP_LD: begin
              // data read goes out on the data bus; fetch just holds its address
              daddr_next = sel_ptr;
              dre_next = 1'b1;
              dst_next = fld_rd;
              pc_next = pc_reg;
              state_next = S_LOAD;
            end
            OP_ST: begin
              daddr_next = sel_ptr;
              dwd_next = rd_b;
              dwe_next = 1'b1;
            end
            OP_LPM: begin
              // table read borrows the program bus, so fetch resumes afterwards
              ret_next = pc_reg;
              pc_next = z_word;
              dst_next = fld_rd;
              vld_next = 1'b0;
              state_next = S_LPM1;
            end
            OP_RJMP: begin
              pc_next = rel_tgt;
              vld_next = 1'b0;
            end
            OP_BRZ: begin
              if (sreg_reg[`CFX_FLAG_Z]) begin
                pc_next = rel_tgt;
                vld_next = 1'b0;
              end
            end
            OP_JMP: state_next = S_JMP2;
            default: state_next = S_RUN;
          endcase
        end
      end
      S_LOAD: begin
        rf_we = 1'b1;
        rf_wa = dst_reg;
        rf_wd = dmem_rdata_i;
        state_next = S_RUN;
      end
      S_LPM1: begin
        pc_next = ret_reg;
        vld_next = 1'b0;
        state_next = S_LPM2;
      end
      S_LPM2: begin
        rf_we = 1'b1;
        rf_wa = dst_reg;
        rf_wd = ptr_z[0] ? ir[15:8] : ir[7:0];
        state_next = S_RUN;
      end
      S_JMP2: begin
        pc_next = ir[PC_W-1:0];
        vld_next = 1'b0;
        state_next = S_RUN;
      end
      default: begin
        vld_next = 1'b0;
        state_next = S_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= S_RUN;
      pc_reg <= PC_W'(`CFX_PC_RST);
      ret_reg <= '0;
      vld_reg <= 1'b0;
      daddr_reg <= '0;
      dwd_reg <= '0;
      dwe_reg <= 1'b0;
      dre_reg <= 1'b0;
      sreg_reg <= `CFX_SREG_RST;
      dst_reg <= '0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      ret_reg <= ret_next;
      vld_reg <= vld_next;
      daddr_reg <= daddr_next;
      dwd_reg <= dwd_next;
      dwe_reg <= dwe_next;
      dre_reg <= dre_next;
      sreg_reg <= sreg_next;
      dst_reg <= dst_next;
    end
  end

  assign imem_addr_o = pc_reg;
  assign dmem_addr_o = daddr_reg;
  assign dmem_wdata_o = dwd_reg;
  assign dmem_we_o = dwe_reg;
  assign dmem_re_o = dre_reg;
  assign status_o = sreg_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_split_buses: assert property (
    exec && op == OP_ST |=> dmem_we_o && imem_addr_o == $past(imem_addr_o) + 1'b1)
    else $error("store disturbed the program fetch");
  a_prefetch_next: assert property (
    exec && op inside {OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_MOV, OP_LDI}
    |=> vld_reg && state_reg == S_RUN && imem_addr_o == $past(imem_addr_o) + 1'b1)
    else $error("next word not prefetched during execute");
  a_alu_one_cycle: assert property (
    exec && op == OP_ADD |-> rf_we && rf_wa == fld_rd && rf_wd == 8'(rd_a + rd_b))
    else $error("add result not written in its own cycle");
  a_ptr_load: assert property (
    exec && op == OP_LD |=> dmem_re_o && dmem_addr_o == $past(sel_ptr)
    ##1 state_reg == S_RUN && !dmem_re_o)
    else $error("load pointer or wait state wrong");
  a_table_addr: assert property (
    exec && op == OP_LPM |=> imem_addr_o == $past(z_word) ##1 state_reg == S_LPM2
    ##1 state_reg == S_RUN && vld_reg)
    else $error("table read address or sequence wrong");
  a_long_jump: assert property (
    exec && op == OP_JMP |=> state_reg == S_JMP2
    ##1 !vld_reg && imem_addr_o == $past(imem_rdata_i))
    else $error("two-word jump not taken from second word");
  a_flag_update: assert property (
    exec && op inside {OP_ADD, OP_SUB} |=> status_o[`CFX_FLAG_Z] == ($past(alu_res) == 8'h00)
    && status_o[`CFX_FLAG_C] == $past(sum[8])
    && status_o[`CFX_FLAG_S] == (status_o[`CFX_FLAG_N] ^ status_o[`CFX_FLAG_V]))
    else $error("status flags do not follow result");
  a_flush_taken: assert property (
    exec && op == OP_RJMP |=> !vld_reg && imem_addr_o == $past(rel_tgt) ##1 vld_reg)
    else $error("prefetched word not discarded on jump");
endmodule
`default_nettype wire

// ===== cfx_defs.svh
// cfx_defs.svh: widths, field positions and reset values of the fetch-execute core
`ifndef CFX_DEFS_SVH
`define CFX_DEFS_SVH

`define CFX_PC_W 16
`define CFX_IW 16
`define CFX_DW 8
`define CFX_AW 16
`define CFX_NREG 32
`define CFX_RA_W 5

`define CFX_OP_HI 15
`define CFX_OP_LO 12
`define CFX_RD_HI 11
`define CFX_RD_LO 7
`define CFX_RS_HI 6
`define CFX_RS_LO 2
`define CFX_PS_HI 1
`define CFX_PS_LO 0
`define CFX_K7_HI 6
`define CFX_K12_HI 11

`define CFX_XL 26
`define CFX_YL 28
`define CFX_ZL 30

`define CFX_FLAG_C 0
`define CFX_FLAG_Z 1
`define CFX_FLAG_N 2
`define CFX_FLAG_V 3
`define CFX_FLAG_S 4
`define CFX_FLAG_H 5

`define CFX_PC_RST 16'h0000
`define CFX_SREG_RST 8'h00
`define CFX_REG_RST 8'h00

`endif

// ===== cfx_mem_model.sv
// cfx_mem_model.sv: program and data memory model facing the fetch-execute core
`default_nettype none
module cfx_mem_model (
  input wire logic ref_clk_i,
  input wire logic [15:0] imem_addr_i,
  output logic [15:0] imem_rdata_o,
  input wire logic [15:0] dmem_addr_i,
  input wire logic [7:0] dmem_wdata_i,
  input wire logic dmem_we_i,
  input wire logic dmem_re_i,
  output logic [7:0] dmem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] prog [0:255];
  logic [7:0] data [0:255];
  logic [7:0] junk = 8'h5a;
  logic [23:0] st_q [$];
  // program words answer one cycle late on their own path
  always @(posedge ref_clk_i) begin
    imem_rdata_o <= prog[imem_addr_i[7:0]];
    junk <= ~junk;
    if (dmem_we_i) begin
      data[dmem_addr_i[7:0]] <= dmem_wdata_i;
      st_q.push_back({dmem_addr_i, dmem_wdata_i});
    end
  end
  // toggling junk when not read, so a late sample never sees a stale byte
  assign dmem_rdata_o = dmem_re_i ? data[dmem_addr_i[7:0]] : junk;
endmodule
`default_nettype wire

// ===== cfx_pkg.sv
// cfx_pkg.sv: types shared by the fetch-execute core
`default_nettype none
package cfx_pkg;
  typedef enum logic [2:0] {
    S_RUN  = 3'b000,
    S_LOAD = 3'b001,
    S_LPM1 = 3'b010,
    S_LPM2 = 3'b011,
    S_JMP2 = 3'b100
  } cfx_state_t;

  typedef enum logic [3:0] {
    OP_NOP  = 4'h0,
    OP_ADD  = 4'h1,
    OP_SUB  = 4'h2,
    OP_AND  = 4'h3,
    OP_OR   = 4'h4,
    OP_MOV  = 4'h5,
    OP_LDI  = 4'h6,
    OP_LD   = 4'h7,
    OP_ST   = 4'h8,
    OP_LPM  = 4'h9,
    OP_RJMP = 4'ha,
    OP_BRZ  = 4'hb,
    OP_JMP  = 4'hc
  } cfx_op_t;
endpackage
`default_nettype wire

// ===== cfx_regfile.sv
// cfx_regfile.sv: 32 x 8 working registers with two read ports and pointer pairs
`default_nettype none
`include "cfx_defs.svh"
module cfx_regfile
  import cfx_pkg::*;
#(
  parameter int NREG = `CFX_NREG
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic we_i,
  input wire logic [`CFX_RA_W-1:0] waddr_i,
  input wire logic [`CFX_DW-1:0] wdata_i,
  input wire logic [`CFX_RA_W-1:0] raddr_a_i,
  input wire logic [`CFX_RA_W-1:0] raddr_b_i,
  output logic [`CFX_DW-1:0] rdata_a_o,
  output logic [`CFX_DW-1:0] rdata_b_o,
  output logic [`CFX_AW-1:0] ptr_x_o,
  output logic [`CFX_AW-1:0] ptr_y_o,
  output logic [`CFX_AW-1:0] ptr_z_o
);
  logic [`CFX_DW-1:0] mem_reg [NREG];
  logic [`CFX_DW-1:0] mem_next [NREG];

  // asynchronous reads keep the whole read-compute-write inside one cycle
  assign rdata_a_o = mem_reg[raddr_a_i];
  assign rdata_b_o = mem_reg[raddr_b_i];
  assign ptr_x_o = {mem_reg[`CFX_XL + 1], mem_reg[`CFX_XL]};
  assign ptr_y_o = {mem_reg[`CFX_YL + 1], mem_reg[`CFX_YL]};
  assign ptr_z_o = {mem_reg[`CFX_ZL + 1], mem_reg[`CFX_ZL]};

  always_comb begin
    mem_next = mem_reg;
    if (we_i) begin
      mem_next[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NREG; i++) begin
        mem_reg[i] <= `CFX_REG_RST;
      end
    end else begin
      mem_reg <= mem_next;
    end
  end

  a_rf_write_read: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    we_i |=> mem_reg[$past(waddr_i)] == $past(wdata_i))
    else $error("register write not visible one cycle later");
endmodule
`default_nettype wire

// ===== tb.sv
// tb.sv: self-checking bench for the fetch-execute core
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] imem_addr;
  logic [15:0] imem_rdata;
  logic [15:0] dmem_addr;
  logic [7:0] dmem_wdata;
  logic [7:0] dmem_rdata;
  logic [7:0] status;
  logic dmem_we;
  logic dmem_re;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  // op, a, b, result, flags {H,S,V,N,Z,C}
  logic [39:0] rows [9] = '{40'h017f01802c, 40'h01ff010023, 40'h020001ff35,
    40'h0280017f38, 40'h03f03c3000, 40'h0480018114, 40'h030ff00002,
    40'h0511999900, 40'h0255550002};

  always #12.5 ref_clk_i = ~ref_clk_i;

  cfx_core #(.PC_W(16)) u_dut (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .imem_addr_o(imem_addr),
    .imem_rdata_i(imem_rdata),
    .dmem_addr_o(dmem_addr),
    .dmem_wdata_o(dmem_wdata),
    .dmem_we_o(dmem_we),
    .dmem_re_o(dmem_re),
    .dmem_rdata_i(dmem_rdata),
    .status_o(status)
  );

  cfx_mem_model u_mem (
    .ref_clk_i(ref_clk_i),
    .imem_addr_i(imem_addr),
    .imem_rdata_o(imem_rdata),
    .dmem_addr_i(dmem_addr),
    .dmem_wdata_i(dmem_wdata),
    .dmem_we_i(dmem_we),
    .dmem_re_i(dmem_re),
    .dmem_rdata_o(dmem_rdata)
  );

  function automatic logic [15:0] ins(input logic [3:0] op, input logic [4:0] rd,
                                      input logic [6:0] k);
    return {op, rd, k};
  endfunction

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // assert reset, clear the store log and blank program memory before a new program
  task automatic hold_rst();
    sys_rst_i = 1'b1;
    u_mem.st_q.delete();
    foreach (u_mem.prog[j]) u_mem.prog[j] = 16'h0000;
  endtask

  task automatic release_rst();
    repeat (6) @(posedge ref_clk_i);
    #2 sys_rst_i = 1'b0;
  endtask

  task automatic wait_st(input int n);
    for (int i = 0; i < 60 && u_mem.st_q.size() < n; i++) @(posedge ref_clk_i);
    #2;
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    hold_rst();
    repeat (3) @(posedge ref_clk_i);
    #2 chk("rst_pc", 24'h0, {8'h00, imem_addr});
    chk("rst_flags", 24'h0, {16'h0000, status});
    chk("rst_strobes", 24'h0, {22'h0, dmem_we, dmem_re});
    repeat (3) @(posedge ref_clk_i);
    #2 sys_rst_i = 1'b0;
    @(posedge ref_clk_i);
    #2 chk("first_fetch", 24'h1, {8'h00, imem_addr});
    // alu table: operands by pointer loads, result stored through Y
    foreach (rows[i]) begin
      hold_rst();
      u_mem.data[0] = rows[i][31:24];
      u_mem.data[1] = rows[i][23:16];
      u_mem.prog[0] = ins(4'h6, 5'd26, 7'h01);
      u_mem.prog[1] = ins(4'h7, 5'd2, 7'h00);
      u_mem.prog[2] = ins(4'h6, 5'd26, 7'h00);
      u_mem.prog[3] = ins(4'h7, 5'd1, 7'h00);
      u_mem.prog[4] = ins(rows[i][35:32], 5'd1, 7'h08);
      u_mem.prog[5] = ins(4'h8, 5'd0, 7'h05);
      u_mem.prog[6] = 16'hafff;
      release_rst();
      wait_st(1);
      chk("alu_store", {16'h0000, rows[i][15:8]}, u_mem.st_q[0]);
      chk("alu_flags", {16'h0000, rows[i][7:0]}, {16'h0000, status});
    end
    // flow: flushed words after jumps, two-word jump, table read via Z
    hold_rst();
    u_mem.prog[0] = ins(4'h6, 5'd3, 7'h05);
    u_mem.prog[1] = 16'ha002;
    u_mem.prog[2] = ins(4'h6, 5'd3, 7'h11);
    u_mem.prog[3] = ins(4'h6, 5'd3, 7'h22);
    u_mem.prog[4] = 16'hc000;
    u_mem.prog[5] = 16'h0007;
    u_mem.prog[6] = ins(4'h6, 5'd3, 7'h33);
    // plain word, then a branch on a clear zero flag that must fall through
    u_mem.prog[7] = 16'h0000;
    u_mem.prog[8] = 16'hb002;
    u_mem.prog[9] = ins(4'h6, 5'd30, 7'h29);
    u_mem.prog[10] = ins(4'h9, 5'd4, 7'h02);
    u_mem.prog[11] = ins(4'h8, 5'd0, 7'h0c);
    u_mem.prog[12] = ins(4'h8, 5'd0, 7'h10);
    u_mem.prog[13] = ins(4'h2, 5'd3, 7'h0c);
    u_mem.prog[14] = 16'hb001;
    u_mem.prog[15] = ins(4'h6, 5'd3, 7'h44);
    u_mem.prog[16] = ins(4'h8, 5'd0, 7'h0d);
    u_mem.prog[17] = 16'hafff;
    u_mem.prog[20] = 16'hbe5a;
    release_rst();
    wait_st(3);
    chk("flow_count", 24'd3, 24'(u_mem.st_q.size()));
    chk("after_jumps", 24'h000005, u_mem.st_q[0]);
    chk("table_byte", 24'h0000be, u_mem.st_q[1]);
    chk("after_branch", 24'h000000, u_mem.st_q[2]);
    chk("zero_flag", 24'h000002, {16'h0000, status});
    // reset in mid-run must clear fetch address and flags without a clock edge
    hold_rst();
    #1 chk("rst_mid_pc", 24'h0, {8'h00, imem_addr});
    chk("rst_mid_flags", 24'h0, {16'h0000, status});
    chk("rst_mid_strobes", 24'h0, {22'h0, dmem_we, dmem_re});
    finish_test();
  end
endmodule
`default_nettype wire
